// ==== core/ecl_pkg.sv ====
package ecl_pkg;

	// Clock and serial bus rates
	localparam int CLK_MHZ = 200;
	localparam int SMB_KHZ = 100;
	// Core cycles per quarter of a serial bit, used as the prescaler reset value
	localparam logic [15:0] QUARTER_RST = 16'(CLK_MHZ * 1000 / (SMB_KHZ * 4));

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_SMB_CTRL = 8'h00;
	localparam logic [7:0] OFS_SMB_STAT = 8'h04;
	localparam logic [7:0] OFS_SW_CTRL = 8'h08;
	localparam logic [7:0] OFS_WIN_CTRL = 8'h0C;
	localparam logic [7:0] OFS_WIN_DATA = 8'h10;

	// Field positions
	localparam int CTRL_IGNORE_BIT = 0;
	localparam int CTRL_QUARTER_LSB = 16;
	localparam int STAT_FINISHED_BIT = 0;
	localparam int STAT_SUM_BIT = 1;
	localparam int STAT_NACK_BIT = 2;
	localparam int STAT_ARB_BIT = 3;
	localparam int STAT_COND_BIT = 4;
	localparam int STAT_UNMAPPED_BIT = 5;
	localparam int SW_HOLD_BIT = 0;
	localparam int WIN_ADDR_LSB = 0;
	localparam int WIN_WRITE_BIT = 16;
	localparam int WIN_BUSY_BIT = 30;
	localparam int WIN_DONE_BIT = 31;

	// Configuration block layout
	localparam int TYPE_LSB = 6;
	localparam logic [1:0] TYPE_SINGLE = 2'h0;
	localparam logic [1:0] TYPE_SEQ = 2'h1;
	localparam logic [1:0] TYPE_BAD = 2'h2;
	localparam logic [1:0] TYPE_DONE = 2'h3;
	localparam logic [7:0] SUM_GOOD = 8'hFF;
	localparam logic [15:0] ROM_LAST = 16'hFFFF;

	// Serial bus constants
	localparam logic [4:0] ARB_LIMIT = 5'h10;
	localparam logic [2:0] ROM_DEV_TOP = 3'h5;
	localparam logic [1:0] BOOT_WAIT = 2'h3;

	// Byte engine commands and states
	typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} ecl_cmd_t;
	typedef enum logic [1:0] {ES_IDLE, ES_START, ES_BIT, ES_STOP} ecl_eng_st_t;

	// Loader sequencing and block parsing states
	typedef enum logic [3:0] {LS_BOOT, LS_IDLE, LS_ASTART, LS_AHI, LS_ALO, LS_RSTART, LS_READ,
		LS_WDATA, LS_DRAIN, LS_STOP} ecl_ld_st_t;
	typedef enum logic [2:0] {PS_HDR0, PS_HDR1, PS_CNT0, PS_CNT1, PS_DATA} ecl_parse_t;

	// Request to the byte engine
	typedef struct packed {
		logic valid;
		ecl_cmd_t kind;
		logic [7:0] data;
		logic ack;
	} ecl_req_t;

	// Answer from the byte engine
	typedef struct packed {
		logic ready;
		logic done;
		logic [7:0] data;
		logic nack;
		logic arbLost;
		logic busErr;
	} ecl_rsp_t;

	// Configuration register write toward the switch core
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [31:0] data;
	} ecl_cfg_wr_t;

endpackage

// ==== core/ecl_smb_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module ecl_smb_master (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command side
	input wire ecl_pkg::ecl_req_t req,
	input wire logic [15:0] quarterCyc,
	output ecl_pkg::ecl_rsp_t rsp,
	// Open-drain bus pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);

	// Whole engine state
	typedef struct packed {
		ecl_pkg::ecl_eng_st_t st;
		logic [15:0] div;      // Quarter-bit divider
		logic [1:0] q;         // Quarter within a bit or condition
		logic [3:0] bitCnt;    // Bit within a nine-bit byte slot
		logic [8:0] shift;     // Bits still to put on the line
		logic isRead;          // Slot reads data from the far side
		logic sclS1;
		logic sclS2;
		logic sdaS1;
		logic sdaS2;
		logic sdaSmp;          // Data seen at the clock high edge
		logic sclOe;
		logic sdaOe;
		logic [7:0] rxByte;
		logic done;
		logic nack;
		logic arbLost;
		logic busErr;
	} ecl_eng_t;

	ecl_eng_t s;
	ecl_eng_t n;
	logic tick;
	logic adv;

	// Next-state logic
	always_comb begin
		n = s;
		adv = 1'b0;
		n.done = 1'b0;
		n.nack = 1'b0;
		n.arbLost = 1'b0;
		n.busErr = 1'b0;
		// Pin synchronisers
		n.sclS1 = sclIn;
		n.sclS2 = s.sclS1;
		n.sdaS1 = sdaIn;
		n.sdaS2 = s.sdaS1;
		tick = (s.div == 16'h0000);
		if (s.st != ecl_pkg::ES_IDLE) begin
			n.div = tick ? quarterCyc - 16'h0001 : s.div - 16'h0001;
		end
		unique case (s.st)
			ecl_pkg::ES_IDLE: begin
				// Accept one command
				if (req.valid) begin
					n.q = 2'h0;
					n.bitCnt = 4'h0;
					n.div = quarterCyc - 16'h0001;
					n.isRead = (req.kind == ecl_pkg::CMD_READ);
					n.shift = (req.kind == ecl_pkg::CMD_READ) ? {8'hFF, ~req.ack} : {req.data, 1'b1};
					unique case (req.kind)
						ecl_pkg::CMD_START: n.st = ecl_pkg::ES_START;
						ecl_pkg::CMD_STOP: n.st = ecl_pkg::ES_STOP;
						default: n.st = ecl_pkg::ES_BIT;
					endcase
				end
			end
			ecl_pkg::ES_START: begin
				// Start or repeated start, then the address byte
				if (tick) begin
					adv = 1'b1;
					unique case (s.q)
						2'h0: n.sdaOe = 1'b0;
						2'h1: n.sclOe = 1'b0;
						2'h2: begin
							if (!s.sclS2) begin
								adv = 1'b0;
							end else if (!s.sdaS2) begin
								// Another master holds data low
								n.arbLost = 1'b1;
							end else begin
								n.sdaOe = 1'b1;
							end
						end
						2'h3: begin
							n.sclOe = 1'b1;
							n.st = ecl_pkg::ES_BIT;
						end
					endcase
				end
			end
			ecl_pkg::ES_BIT: begin
				// One bit per four quarters
				if (tick) begin
					adv = 1'b1;
					unique case (s.q)
						2'h0: n.sdaOe = ~s.shift[8];
						2'h1: n.sclOe = 1'b0;
						2'h2: begin
							if (s.sclS2) begin
								n.sdaSmp = s.sdaS2;
							end else begin
								adv = 1'b0;
							end
						end
						2'h3: begin
							if (s.sdaS2 != s.sdaSmp) begin
								// Data moved while clock high: misplaced condition
								n.busErr = 1'b1;
							end else if (s.shift[8] && !s.sdaSmp &&
								(s.isRead ? (s.bitCnt == 4'h8) : (s.bitCnt != 4'h8))) begin
								// Released a one but saw a zero
								n.arbLost = 1'b1;
							end else begin
								n.sclOe = 1'b1;
								n.shift = {s.shift[7:0], 1'b0};
								if (s.bitCnt != 4'h8) begin
									n.rxByte = {s.rxByte[6:0], s.sdaSmp};
									n.bitCnt = s.bitCnt + 4'h1;
								end else begin
									// Acknowledge slot ends the byte; only a written byte can report a nack
									n.nack = ~s.isRead & s.sdaSmp;
									n.done = 1'b1;
									n.st = ecl_pkg::ES_IDLE;
								end
							end
						end
					endcase
				end
			end
			ecl_pkg::ES_STOP: begin
				// Stop condition
				if (tick) begin
					adv = 1'b1;
					unique case (s.q)
						2'h0: n.sdaOe = 1'b1;
						2'h1: n.sclOe = 1'b0;
						2'h2: adv = s.sclS2;
						2'h3: begin
							n.sdaOe = 1'b0;
							n.done = 1'b1;
							n.st = ecl_pkg::ES_IDLE;
						end
					endcase
				end
			end
		endcase
		if (adv) begin
			n.q = s.q + 2'h1;
		end
		// Arbitration loss or bus error releases the bus at once
		if (n.arbLost || n.busErr) begin
			n.sclOe = 1'b0;
			n.sdaOe = 1'b0;
			n.done = 1'b1;
			n.st = ecl_pkg::ES_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = s.sclOe;
	assign sdaOe = s.sdaOe;
	assign rsp.ready = (s.st == ecl_pkg::ES_IDLE);
	assign rsp.done = s.done;
	assign rsp.data = s.rxByte;
	assign rsp.nack = s.nack;
	assign rsp.arbLost = s.arbLost;
	assign rsp.busErr = s.busErr;

endmodule

`default_nettype wire

// ==== core/ecl_loader.sv ====
`timescale 1ns/1ps
`default_nettype none

module ecl_loader (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Straps
	input wire logic eepromLoadSel,
	input wire logic [3:0] romAddrPins,
	// Serial bus pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Configuration writes
	output ecl_pkg::ecl_cfg_wr_t cfgWr,
	input wire logic cfgMapped,
	// Status
	output logic holdInReset,
	output logic loadFinished
);

	// Whole loader state
	typedef struct packed {
		ecl_pkg::ecl_ld_st_t st;
		ecl_pkg::ecl_parse_t pst;
		logic waiting;           // Command issued, answer pending
		logic host;              // Current transfer belongs to the host window
		logic failed;            // Transfer ends in error
		logic aborted;           // Load aborted, no more writes
		logic [1:0] boot;
		logic selS1;
		logic selS2;
		logic [3:0] devS1;
		logic [3:0] devS2;
		logic [15:0] romAddr;    // Next byte to read
		logic [7:0] sum;
		logic [4:0] arbCnt;
		logic [13:0] dwAddr;
		logic [15:0] dwCnt;
		logic [31:0] dword;
		logic [1:0] bIdx;
		logic emit;
		logic [15:0] emitAddr;
		logic [31:0] emitData;
		logic ignoreSum;
		logic [15:0] quarter;
		logic finished;
		logic sumErr;
		logic nackErr;
		logic arbErr;
		logic condErr;
		logic unmapped;
		logic hold;
		logic [15:0] winAddr;
		logic winWrite;
		logic winBusy;
		logic winDone;
		logic [7:0] winData;
		logic [31:0] rdata;
	} ecl_ld_t;

	ecl_ld_t s;
	ecl_ld_t n;
	ecl_pkg::ecl_req_t req;
	ecl_pkg::ecl_rsp_t rsp;
	logic [6:0] devAddr;
	logic [7:0] newSum;
	logic [1:0] blkType;
	logic issue;
	logic abortNow;
	logic finishNow;

	// Byte engine on the serial bus
	ecl_smb_master uEngine (
		.clk(clk),
		.rst(rst),
		.req(req),
		.quarterCyc(s.quarter),
		.rsp(rsp),
		.sclIn(sclIn),
		.sclOut(sclOut),
		.sclOe(sclOe),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe)
	);

	// Next-state logic
	always_comb begin
		n = s;
		req = '0;
		abortNow = 1'b0;
		finishNow = 1'b0;
		n.emit = 1'b0;
		n.rdata = '0;
		// Strap synchronisers
		n.selS1 = eepromLoadSel;
		n.selS2 = s.selS1;
		n.devS1 = romAddrPins;
		n.devS2 = s.devS1;
		devAddr = {ecl_pkg::ROM_DEV_TOP, s.devS2};
		newSum = 8'(s.sum + rsp.data);
		blkType = rsp.data[ecl_pkg::TYPE_LSB +: 2];

		// Register writes; clears come first so hardware sets below win
		if (regWr) begin
			case (regAddr)
				ecl_pkg::OFS_SMB_CTRL: begin
					n.ignoreSum = regWdata[ecl_pkg::CTRL_IGNORE_BIT];
					n.quarter = regWdata[ecl_pkg::CTRL_QUARTER_LSB +: 16];
				end
				ecl_pkg::OFS_SMB_STAT: begin
					// Write one to clear
					n.sumErr = s.sumErr & ~regWdata[ecl_pkg::STAT_SUM_BIT];
					n.nackErr = s.nackErr & ~regWdata[ecl_pkg::STAT_NACK_BIT];
					n.arbErr = s.arbErr & ~regWdata[ecl_pkg::STAT_ARB_BIT];
					n.condErr = s.condErr & ~regWdata[ecl_pkg::STAT_COND_BIT];
					n.unmapped = s.unmapped & ~regWdata[ecl_pkg::STAT_UNMAPPED_BIT];
				end
				ecl_pkg::OFS_SW_CTRL: n.hold = regWdata[ecl_pkg::SW_HOLD_BIT];
				ecl_pkg::OFS_WIN_CTRL: begin
					if (!s.winBusy) begin
						n.winAddr = regWdata[ecl_pkg::WIN_ADDR_LSB +: 16];
						n.winWrite = regWdata[ecl_pkg::WIN_WRITE_BIT];
					end
					n.winDone = s.winDone & ~regWdata[ecl_pkg::WIN_DONE_BIT];
				end
				ecl_pkg::OFS_WIN_DATA: begin
					// Writing data starts the access; ignored while busy
					if (!s.winBusy) begin
						n.winData = regWdata[7:0];
						n.winBusy = 1'b1;
						n.winDone = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Register reads, answered next cycle
		if (regRd) begin
			case (regAddr)
				ecl_pkg::OFS_SMB_CTRL: begin
					n.rdata[ecl_pkg::CTRL_IGNORE_BIT] = s.ignoreSum;
					n.rdata[ecl_pkg::CTRL_QUARTER_LSB +: 16] = s.quarter;
				end
				ecl_pkg::OFS_SMB_STAT: begin
					n.rdata[ecl_pkg::STAT_FINISHED_BIT] = s.finished;
					n.rdata[ecl_pkg::STAT_SUM_BIT] = s.sumErr;
					n.rdata[ecl_pkg::STAT_NACK_BIT] = s.nackErr;
					n.rdata[ecl_pkg::STAT_ARB_BIT] = s.arbErr;
					n.rdata[ecl_pkg::STAT_COND_BIT] = s.condErr;
					n.rdata[ecl_pkg::STAT_UNMAPPED_BIT] = s.unmapped;
				end
				ecl_pkg::OFS_SW_CTRL: n.rdata[ecl_pkg::SW_HOLD_BIT] = s.hold;
				ecl_pkg::OFS_WIN_CTRL: begin
					n.rdata[ecl_pkg::WIN_ADDR_LSB +: 16] = s.winAddr;
					n.rdata[ecl_pkg::WIN_WRITE_BIT] = s.winWrite;
					n.rdata[ecl_pkg::WIN_BUSY_BIT] = s.winBusy;
					n.rdata[ecl_pkg::WIN_DONE_BIT] = s.winDone;
				end
				ecl_pkg::OFS_WIN_DATA: n.rdata[7:0] = s.winData;
				default: n.rdata = '0;
			endcase
		end

		// Dropped write to an undecoded register
		if (s.emit && !cfgMapped && !s.aborted) begin
			n.unmapped = 1'b1;
		end

		// Command for the current state
		issue = 1'b1;
		req.ack = 1'b0;
		req.data = 8'h00;
		unique case (s.st)
			ecl_pkg::LS_ASTART: begin
				req.kind = ecl_pkg::CMD_START;
				req.data = {devAddr, 1'b0};
			end
			ecl_pkg::LS_AHI: begin
				req.kind = ecl_pkg::CMD_WRITE;
				req.data = s.romAddr[15:8];
			end
			ecl_pkg::LS_ALO: begin
				req.kind = ecl_pkg::CMD_WRITE;
				req.data = s.romAddr[7:0];
			end
			ecl_pkg::LS_RSTART: begin
				req.kind = ecl_pkg::CMD_START;
				req.data = {devAddr, 1'b1};
			end
			ecl_pkg::LS_READ: begin
				// Loader streams with acknowledge, host takes one byte
				req.kind = ecl_pkg::CMD_READ;
				req.ack = ~s.host;
			end
			ecl_pkg::LS_WDATA: begin
				req.kind = ecl_pkg::CMD_WRITE;
				req.data = s.winData;
			end
			ecl_pkg::LS_DRAIN: req.kind = ecl_pkg::CMD_READ;
			ecl_pkg::LS_STOP: req.kind = ecl_pkg::CMD_STOP;
			default: begin
				req.kind = ecl_pkg::CMD_STOP;
				issue = 1'b0;
			end
		endcase
		req.valid = issue & ~s.waiting & rsp.ready;
		if (req.valid) begin
			n.waiting = 1'b1;
		end

		// Sequencing
		unique case (s.st)
			ecl_pkg::LS_BOOT: begin
				// Let the strap synchronisers settle, then decide
				n.boot = s.boot + 2'h1;
				if (s.boot == ecl_pkg::BOOT_WAIT) begin
					n.st = s.selS2 ? ecl_pkg::LS_ASTART : ecl_pkg::LS_IDLE;
				end
			end
			ecl_pkg::LS_IDLE: begin
				// Host window access once loading is over
				if (s.winBusy) begin
					n.host = 1'b1;
					n.failed = 1'b0;
					n.romAddr = s.winAddr;
					n.arbCnt = 5'h00;
					n.st = ecl_pkg::LS_ASTART;
				end
			end
			default: begin
				if (s.waiting && rsp.done) begin
					n.waiting = 1'b0;
					if (rsp.arbLost) begin
						// Count straight losses, retry from current address
						if (s.arbCnt == ecl_pkg::ARB_LIMIT - 5'h01) begin
							n.arbErr = 1'b1;
							abortNow = 1'b1;
						end else begin
							n.arbCnt = s.arbCnt + 5'h01;
							n.st = ecl_pkg::LS_ASTART;
						end
					end else if (rsp.busErr) begin
						// Bus already released by the engine
						n.condErr = 1'b1;
						abortNow = 1'b1;
					end else if (rsp.nack) begin
						// Close the bus with a stop, then end
						n.nackErr = 1'b1;
						n.failed = 1'b1;
						n.st = ecl_pkg::LS_STOP;
					end else begin
						n.arbCnt = 5'h00;
						unique case (s.st)
							ecl_pkg::LS_ASTART: n.st = ecl_pkg::LS_AHI;
							ecl_pkg::LS_AHI: n.st = ecl_pkg::LS_ALO;
							ecl_pkg::LS_ALO: n.st = (s.host && s.winWrite) ? ecl_pkg::LS_WDATA : ecl_pkg::LS_RSTART;
							ecl_pkg::LS_RSTART: n.st = ecl_pkg::LS_READ;
							ecl_pkg::LS_WDATA: n.st = ecl_pkg::LS_STOP;
							ecl_pkg::LS_DRAIN: n.st = ecl_pkg::LS_STOP;
							ecl_pkg::LS_STOP: finishNow = 1'b1;
							default: begin
								if (s.host) begin
									// Host byte captured
									n.winData = rsp.data;
									n.st = ecl_pkg::LS_STOP;
								end else begin
									// Running sum over every byte
									n.sum = newSum;
									n.romAddr = s.romAddr + 16'h0001;
									unique case (s.pst)
										ecl_pkg::PS_HDR0: begin
											n.dwAddr[7:0] = rsp.data;
											n.pst = ecl_pkg::PS_HDR1;
										end
										ecl_pkg::PS_HDR1: begin
											n.dwAddr[13:8] = rsp.data[ecl_pkg::TYPE_LSB - 1:0];
											n.bIdx = 2'h0;
											// Block type decode
											if (blkType == ecl_pkg::TYPE_SINGLE) begin
												n.dwCnt = 16'h0001;
												n.pst = ecl_pkg::PS_DATA;
											end else if (blkType == ecl_pkg::TYPE_SEQ) begin
												n.pst = ecl_pkg::PS_CNT0;
											end else if (blkType == ecl_pkg::TYPE_BAD) begin
												// Undefined type
												n.sumErr = 1'b1;
												n.failed = 1'b1;
											end else begin
												// Done block: test the total
												if (newSum != ecl_pkg::SUM_GOOD && !s.ignoreSum) begin
													n.sumErr = 1'b1;
													n.failed = 1'b1;
												end
												n.st = ecl_pkg::LS_DRAIN;
											end
										end
										ecl_pkg::PS_CNT0: begin
											n.dwCnt[7:0] = rsp.data;
											n.pst = ecl_pkg::PS_CNT1;
										end
										ecl_pkg::PS_CNT1: begin
											n.dwCnt[15:8] = rsp.data;
											n.pst = ({rsp.data, s.dwCnt[7:0]} == 16'h0000) ? ecl_pkg::PS_HDR0
												: ecl_pkg::PS_DATA;
										end
										ecl_pkg::PS_DATA: begin
											// Little-endian dword assembly
											n.dword = {rsp.data, s.dword[31:8]};
											n.bIdx = s.bIdx + 2'h1;
											if (s.bIdx == 2'h3) begin
												n.emit = 1'b1;
												n.emitAddr = {s.dwAddr, 2'b00};
												n.emitData = {rsp.data, s.dword[31:8]};
												n.dwAddr = s.dwAddr + 14'h0001;
												n.dwCnt = s.dwCnt - 16'h0001;
												if (s.dwCnt == 16'h0001) begin
													n.pst = ecl_pkg::PS_HDR0;
												end
											end
										end
									endcase
									// Stop on error or at wrap
									if (n.failed || s.romAddr == ecl_pkg::ROM_LAST) begin
										n.emit = n.emit & ~n.failed;
										n.st = ecl_pkg::LS_DRAIN;
									end
								end
							end
						endcase
					end
				end
			end
		endcase

		// Abort paths that skip the stop condition
		if (abortNow) begin
			n.failed = 1'b1;
			finishNow = 1'b1;
		end
		// Load error holds the switch in reset; hold is set again every cycle until a host window access clears the failed flag
		if (n.failed && !s.host) begin
			n.hold = 1'b1;
			n.aborted = 1'b1;
		end
		// End of a transfer
		if (finishNow) begin
			n.st = ecl_pkg::LS_IDLE;
			if (s.host) begin
				// Host access complete
				n.winBusy = 1'b0;
				n.winDone = 1'b1;
			end else begin
				// Finished on success and on error
				n.finished = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.quarter <= ecl_pkg::QUARTER_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign regRdata = s.rdata;
	assign cfgWr.valid = s.emit & cfgMapped & ~s.aborted;
	assign cfgWr.addr = s.emitAddr;
	assign cfgWr.data = s.emitData;
	assign holdInReset = s.hold;
	assign loadFinished = s.finished;

endmodule

`default_nettype wire

// ==== sim/ecl_loader_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic regWr,
	input wire logic sclOe,
	input wire logic sdaOe,
	input wire ecl_pkg::ecl_cfg_wr_t cfgWr,
	input wire logic cfgMapped,
	input wire logic holdInReset,
	input wire logic loadFinished
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Hold raised by hardware, not by software
	sequence s_holdRise;
		$rose(holdInReset) && !$past(regWr);
	endsequence
	// Bus left alone while straps settle
	sequence s_bootIdle;
		(!sclOe && !sdaOe) [*3];
	endsequence
	// A sum or type error drains one byte and sends a stop before finishing, with the bench's short bit time
	property p_holdBringsFinish;
		s_holdRise |-> ##[0:400] loadFinished;
	endproperty
	a_holdBringsFinish: assert property (p_holdBringsFinish) else $error("hold without finish");
	property p_finishedStays;
		loadFinished |=> loadFinished;
	endproperty
	a_finishedStays: assert property (p_finishedStays) else $error("finish flag dropped");
	property p_quietAfterFinish;
		loadFinished |-> !cfgWr.valid;
	endproperty
	a_quietAfterFinish: assert property (p_quietAfterFinish) else $error("write after finish");
	property p_cfgAligned;
		cfgWr.valid |-> cfgWr.addr[1:0] == 2'h0;
	endproperty
	a_cfgAligned: assert property (p_cfgAligned) else $error("write address not word aligned");
	property p_cfgMapped;
		cfgWr.valid |-> cfgMapped;
	endproperty
	a_cfgMapped: assert property (p_cfgMapped) else $error("unmapped write issued");
	property p_cfgSpaced;
		cfgWr.valid |=> !cfgWr.valid [*8];
	endproperty
	a_cfgSpaced: assert property (p_cfgSpaced) else $error("writes too close");
	property p_bootQuiet;
		$fell(rst) |-> s_bootIdle;
	endproperty
	a_bootQuiet: assert property (p_bootQuiet) else $error("bus driven during boot");
	property p_holdStays;
		holdInReset && !regWr |=> holdInReset;
	endproperty
	a_holdStays: assert property (p_holdStays) else $error("hold dropped by itself");
endmodule
bind ecl_loader ecl_loader_asserts u_chk (.clk(clk), .rst(rst), .regWr(regWr), .sclOe(sclOe), .sdaOe(sdaOe),
	.cfgWr(cfgWr), .cfgMapped(cfgMapped), .holdInReset(holdInReset), .loadFinished(loadFinished));
`default_nettype wire

// ==== sim/ecl_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecl_rom_model (
	// Resolved bus lines
	input wire logic scl,
	input wire logic sda,
	// Open-drain pulls
	output logic sclLow,
	output logic sdaLow,
	// Bench controls
	input wire logic nackAll,
	input wire logic slow
);
	logic [7:0] mem [0:65535]; // Byte array
	logic [7:0] sh; // Shift register
	logic [15:0] ptr; // Byte pointer
	logic act, rd; // Selected, read direction
	int bitN, byteN;
	initial begin
		sclLow = 0;
		sdaLow = 0;
		act = 0;
		rd = 0;
		foreach (mem[i]) mem[i] = 8'hFF; // Blank part reads all ones
	end
	// Start condition
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1;
		rd = 0;
		bitN = -1;
		byteN = 0;
	end
	// Stop condition
	always @(posedge sda) if (scl === 1'b1) act = 0;
	// Sample master bits; a NACK ends our sending
	always @(posedge scl) if (act) begin
		if (bitN < 8 && !(rd && byteN > 0)) sh = {sh[6:0], sda};
		if (bitN == 8 && rd && byteN > 1 && sda) act = 0;
	end
	// Drive after the clock falls, then maybe stretch it
	always @(negedge scl) if (act) begin
		#1;
		bitN = (bitN == 8) ? 0 : bitN + 1;
		if (bitN == 8 && !(rd && byteN > 0)) begin
			if (byteN == 0) rd = sh[0];
			else if (byteN == 1) ptr[15:8] = sh;
			else if (byteN == 2) ptr[7:0] = sh;
			else begin
				mem[ptr] = sh;
				ptr++;
			end
			sdaLow = !nackAll;
			byteN++;
		end else if (rd && byteN > 0) begin
			if (bitN == 0) begin
				sh = mem[ptr];
				ptr++;
			end
			sdaLow = (bitN == 8) ? 1'b0 : !sh[7 - bitN];
			if (bitN == 8) byteN++;
		end else sdaLow = 0;
		if (slow) begin
			sclLow = 1;
			#100;
			sclLow = 0;
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_ecl_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ecl_loader;
	logic clk, rst, regWr, regRd, eepromLoadSel, cfgMapped, nackAll, slow, sclOe, sdaOe, romScl, romSda, jam;
	logic holdInReset, loadFinished;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, d;
	logic [15:0] firstA, lastA;
	logic [31:0] firstD, lastD;
	ecl_pkg::ecl_cfg_wr_t cfgWr;
	wire scl = ~(sclOe | romScl); // Pull-up on both lines
	wire sda = ~(sdaOe | romSda | jam); // Jam stands for another master holding data low
	int mismatches, samples_checked, cyc, nCfg, r;
	logic [7:0] img [0:19] = '{8'h10, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11, 8'h20, 8'h40, 8'h02, 8'h00,
		8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'hC0};
	// Per run: mode, ignore, nack, status, hold, writes
	int md [6] = '{0, 0, 2, 1, 1, 0};
	int ig [6] = '{0, 0, 0, 0, 1, 0};
	int nk [6] = '{0, 1, 0, 0, 0, 0};
	logic [7:0] st [6] = '{8'h09, 8'h05, 8'h03, 8'h23, 8'h21, 8'h21};
	int hd [6] = '{1, 1, 1, 1, 0, 0};
	int nw [6] = '{0, 0, 0, 2, 2, 2};
	assign cfgMapped = (cfgWr.addr !== 16'h0084); // One hole in the map
	ecl_loader dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .eepromLoadSel(eepromLoadSel), .romAddrPins(4'h3), .sclIn(scl), .sclOut(),
		.sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .cfgWr(cfgWr), .cfgMapped(cfgMapped),
		.holdInReset(holdInReset), .loadFinished(loadFinished));
	ecl_rom_model rom (.scl(scl), .sda(sda), .sclLow(romScl), .sdaLow(romSda), .nackAll(nackAll), .slow(slow));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Record issued configuration writes
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			mismatches++;
			summarize();
		end
		if (cfgWr.valid === 1'b1) begin
			if (nCfg == 0) {firstA, firstD} = {cfgWr.addr, cfgWr.data};
			{lastA, lastD} = {cfgWr.addr, cfgWr.data};
			nCfg++;
		end
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic regWrite(logic [7:0] a, logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic regRead(logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	// Poll until the window is no longer busy
	task automatic waitIdle();
		int k;
		k = 0;
		d = 32'h4000_0000;
		while (d[30] !== 1'b0 && k < 3000) begin
			regRead(ecl_pkg::OFS_WIN_CTRL, d);
			k++;
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] s;
		int k;
		{rst, regWr, regRd, regAddr, regWdata, nackAll, slow, jam} = '0;
		rst = 1'b1;
		eepromLoadSel = 1'b1;
		for (r = 0; r < 6; r++) begin
			// Image loaded after the model's own start-up fill
			@(posedge clk);
			s = 8'h3F; // Sum target minus done type byte
			for (k = 0; k < 20; k++) rom.mem[k] = img[k];
			for (k = 0; k < 18; k++) s -= img[k];
			rom.mem[18] = s + 8'(md[r] == 1); // Mode 1 spoils the sum
			if (md[r] == 2) rom.mem[1] = 8'h80; // Type code two
			nackAll <= nk[r][0];
			slow <= (r == 5);
			jam <= (r == 0); // Every start loses arbitration in run 0
			nCfg = 0;
			rst <= 1'b1;
			repeat (6) @(posedge clk);
			rst <= 1'b0;
			regWrite(ecl_pkg::OFS_SMB_CTRL, {16'h0002, 15'h0000, ig[r][0]});
			k = 0;
			while (loadFinished !== 1'b1 && k < 20000) begin
				@(posedge clk);
				k++;
			end
			repeat (300) @(posedge clk);
			chk("finished", {31'h0, loadFinished}, 32'h1);
			regRead(ecl_pkg::OFS_SMB_STAT, d);
			chk("status", d, {24'h0, st[r]});
			chk("hold", {31'h0, holdInReset}, 32'(hd[r]));
			chk("writes", 32'(nCfg), 32'(nw[r]));
			$display("load run %0d done", r);
		end
		chk("first", {firstA, firstD[15:0]}, 32'h0040_3344);
		chk("last", {lastA, lastD[31:16]}, 32'h0080_DDCC);
		regRead(ecl_pkg::OFS_SMB_STAT, d);
		chk("pre status", d, 32'h21);
		regWrite(ecl_pkg::OFS_WIN_CTRL, 32'h0000_0002);
		waitIdle();
		regWrite(ecl_pkg::OFS_WIN_DATA, 32'h0);
		waitIdle();
		chk("read done", {30'h0, d[31:30]}, 32'h2);
		regRead(ecl_pkg::OFS_WIN_DATA, d);
		chk("read byte", d & 32'hFF, 32'h44);
		regWrite(ecl_pkg::OFS_WIN_CTRL, 32'h8001_0100);
		regWrite(ecl_pkg::OFS_WIN_DATA, 32'h5A);
		regRead(ecl_pkg::OFS_WIN_CTRL, d);
		chk("write busy", {30'h0, d[31:30]}, 32'h1);
		waitIdle();
		chk("write done", {30'h0, d[31:30]}, 32'h2);
		chk("rom byte", {24'h0, rom.mem[16'h0100]}, 32'h5A);
		regRead(ecl_pkg::OFS_SMB_STAT, d);
		chk("host status", d, 32'h21);
		regRead(8'h14, d);
		chk("unmapped reg", d, 32'h0);
		$display("window test done");
		summarize();
	end
endmodule
`default_nettype wire
